// >>> switch_regs.sv
// Register slice: priority maps, indirect table port, AXI4-Lite slave
`timescale 1ns/1ps
module switch_regs import swreg_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AXI4-Lite write address
  input wire logic [31:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [31:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Priority lookup
  input wire logic LOOKUP_VALID,
  input wire logic [7:0] TOS_CODE,
  output logic PRIORITY_VALID,
  output logic PRIORITY_HIT,
  output logic [1:0] PRIORITY,
  // Interrupt
  output logic IRQ
);

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  function automatic logic [11:0] reg_index(input logic [31:0] addr);
    return addr[13:2];
  endfunction

  function automatic logic is_mapped(input logic [31:0] addr);
    logic [11:0] idx;
    logic hit;
    idx = reg_index(addr);
    hit = 1'b0;
    if (addr[31:14] != 18'h0) begin
      hit = 1'b0;
    end else if (idx == IDX_MAP6 || idx == IDX_MAP7 || idx == IDX_MAP8) begin
      hit = 1'b1;
    end else if (idx >= IDX_RSVD_LO && idx <= IDX_RSVD_HI) begin
      hit = 1'b1;
    end else if (idx >= IDX_CMD && idx <= IDX_DATA_LOWER_MID) begin
      hit = !idx[0];
    end else if (idx >= IDX_IRQ_STATUS && idx <= IDX_IRQ_ENABLE) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Two-bit field for code bits [4:2] inside one map
  function automatic logic [1:0] pick(input logic [15:0] map,
                                      input logic [7:0] code);
    return map[{code[4:2], 1'b0} +: 2];
  endfunction

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  logic [15:0] map6_q;
  logic [15:0] map7_q;
  logic [15:0] map8_q;
  logic [15:0] cmd_q;
  logic [2:0] data_top_q;
  logic pending_q;
  logic [15:0] data_mid_q;
  logic [15:0] data_upper_q;
  logic [15:0] data_low_q;
  logic [15:0] data_lower_mid_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_enable_q;

  logic aw_full_q;
  logic [31:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic do_write;
  logic [11:0] w_idx;
  logic lane_hit;
  logic launch;
  table_cmd_t new_cmd;
  table_entry_t wr_entry;
  table_entry_t rd_entry;
  logic eng_busy;
  logic eng_done;
  logic eng_done_read;

  //------------------------------------------------------------
  // Write channels
  //------------------------------------------------------------
  assign AWREADY = !aw_full_q;
  assign WREADY = !w_full_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign w_idx = reg_index(aw_addr_q);
  assign lane_hit = (w_strb_q[1:0] != 2'h0);

  // Address and data are taken in either order, then paired
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 32'h0;
    end else if (AWVALID && !aw_full_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= AWADDR;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (WVALID && !w_full_q) begin
      w_full_q <= 1'b1;
      w_data_q <= WDATA;
      w_strb_q <= WSTRB;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Priority maps
  //------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      map6_q <= MAP_RST;
      map7_q <= MAP_RST;
      map8_q <= MAP_RST;
    end else if (do_write && aw_addr_q[31:14] == 18'h0) begin
      if (w_idx == IDX_MAP6) begin
        map6_q <= merge16(map6_q, w_data_q, w_strb_q);
      end else if (w_idx == IDX_MAP7) begin
        map7_q <= merge16(map7_q, w_data_q, w_strb_q);
      end else if (w_idx == IDX_MAP8) begin
        map8_q <= merge16(map8_q, w_data_q, w_strb_q);
      end
    end
  end

  // Codes below 0xa0 belong to maps outside this slice: no hit
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRIORITY_VALID <= 1'b0;
      PRIORITY_HIT <= 1'b0;
      PRIORITY <= 2'h0;
    end else begin
      PRIORITY_VALID <= LOOKUP_VALID;
      PRIORITY_HIT <= 1'b0;
      PRIORITY <= 2'h0;
      if (LOOKUP_VALID) begin
        case (TOS_CODE[7:5])
          3'h5: begin
            PRIORITY_HIT <= 1'b1;
            PRIORITY <= pick(map6_q, TOS_CODE);
          end
          3'h6: begin
            PRIORITY_HIT <= 1'b1;
            PRIORITY <= pick(map7_q, TOS_CODE);
          end
          3'h7: begin
            PRIORITY_HIT <= 1'b1;
            PRIORITY <= pick(map8_q, TOS_CODE);
          end
          default: begin
            PRIORITY_HIT <= 1'b0;
          end
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // Indirect command
  //------------------------------------------------------------
  assign new_cmd.is_read = w_data_q[CMD_DIR_BIT];
  assign new_cmd.table_sel = table_sel_t'(w_data_q[CMD_TBL_LSB +: 2]);
  assign new_cmd.index = w_data_q[CMD_IDX_MSB:0];
  // A write while a command runs stores the fields but starts nothing
  assign launch = do_write && aw_addr_q[31:14] == 18'h0 && w_idx == IDX_CMD
                  && lane_hit && !eng_busy;

  assign wr_entry.top = data_top_q;
  assign wr_entry.upper = data_upper_q;
  assign wr_entry.mid = data_mid_q;
  assign wr_entry.lower_mid = data_lower_mid_q;
  assign wr_entry.low = data_low_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_q <= CMD_RST;
    end else if (do_write && aw_addr_q[31:14] == 18'h0 && w_idx == IDX_CMD) begin
      cmd_q <= merge16(cmd_q, w_data_q, w_strb_q);
    end
  end

  table_engine u_engine (
    .clk(CLK),
    .rst(RST),
    .start(launch),
    .cmd(new_cmd),
    .wr_entry(wr_entry),
    .busy(eng_busy),
    .done(eng_done),
    .done_read(eng_done_read),
    .rd_entry(rd_entry)
  );

  // Pending only for the slow tables; fast tables never raise it
  always_ff @(posedge CLK) begin
    if (RST) begin
      pending_q <= 1'b0;
    end else if (launch && new_cmd.is_read
                 && (new_cmd.table_sel == TBL_DYNAMIC
                     || new_cmd.table_sel == TBL_MIB)) begin
      pending_q <= 1'b1;
    end else if (eng_done) begin
      pending_q <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Data registers
  //------------------------------------------------------------
  // A finishing read overrides a software write in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      data_top_q <= DATA_RST[2:0];
      data_mid_q <= DATA_RST;
      data_upper_q <= DATA_RST;
      data_low_q <= DATA_RST;
      data_lower_mid_q <= DATA_RST;
    end else if (eng_done_read) begin
      data_top_q <= rd_entry.top;
      data_mid_q <= rd_entry.mid;
      data_upper_q <= rd_entry.upper;
      data_low_q <= rd_entry.low;
      data_lower_mid_q <= rd_entry.lower_mid;
    end else if (do_write && aw_addr_q[31:14] == 18'h0) begin
      if (w_idx == IDX_DATA_MID) begin
        data_mid_q <= merge16(data_mid_q, w_data_q, w_strb_q);
      end else if (w_idx == IDX_DATA_UPPER) begin
        data_upper_q <= merge16(data_upper_q, w_data_q, w_strb_q);
      end else if (w_idx == IDX_DATA_LOW) begin
        data_low_q <= merge16(data_low_q, w_data_q, w_strb_q);
      end else if (w_idx == IDX_DATA_LOWER_MID) begin
        data_lower_mid_q <= merge16(data_lower_mid_q, w_data_q, w_strb_q);
      end
    end
  end

  //------------------------------------------------------------
  // Interrupts
  //------------------------------------------------------------
  logic irq_clear_hit;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  assign irq_clear_hit = do_write && aw_addr_q[31:14] == 18'h0
                         && w_idx == IDX_IRQ_CLEAR && w_strb_q[0];
  assign irq_clr = irq_clear_hit ? w_data_q[1:0] : 2'h0;
  assign irq_set[IRQ_READ_DONE] = eng_done_read;
  assign irq_set[IRQ_WRITE_DONE] = eng_done && !eng_done_read;

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_status_q <= IRQ_RST;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_enable_q <= IRQ_RST;
    end else if (do_write && aw_addr_q[31:14] == 18'h0
                 && w_idx == IDX_IRQ_ENABLE && w_strb_q[0]) begin
      irq_enable_q <= w_data_q[1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status_q & irq_enable_q);
    end
  end

  //------------------------------------------------------------
  // Read channel
  //------------------------------------------------------------
  function automatic logic [15:0] read_mux(input logic [11:0] idx);
    logic [15:0] val;
    val = 16'h0000;
    if (idx == IDX_MAP6) begin
      val = map6_q;
    end else if (idx == IDX_MAP7) begin
      val = map7_q;
    end else if (idx == IDX_MAP8) begin
      val = map8_q;
    end else if (idx >= IDX_RSVD_LO && idx <= IDX_RSVD_HI) begin
      val = 16'h0000;
    end else if (idx == IDX_CMD) begin
      val = cmd_q;
    end else if (idx == IDX_DATA_TOP) begin
      val = {8'h00, pending_q, 4'h0, data_top_q};
    end else if (idx == IDX_DATA_MID) begin
      val = data_mid_q;
    end else if (idx == IDX_DATA_UPPER) begin
      val = data_upper_q;
    end else if (idx == IDX_DATA_LOW) begin
      val = data_low_q;
    end else if (idx == IDX_DATA_LOWER_MID) begin
      val = data_lower_mid_q;
    end else if (idx == IDX_IRQ_STATUS) begin
      val = {14'h0, irq_status_q};
    end else if (idx == IDX_IRQ_ENABLE) begin
      val = {14'h0, irq_enable_q};
    end
    return val;
  endfunction

  assign ARREADY = !rvalid_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      if (is_mapped(ARADDR)) begin
        rdata_q <= {16'h0000, read_mux(reg_index(ARADDR))};
        rresp_q <= RESP_OKAY;
      end else begin
        rdata_q <= 32'h0;
        rresp_q <= RESP_SLVERR;
      end
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// >>> swreg_pkg.sv
// Package: map, fields, types and timing of the switch register slice
//------------------------------------------------------------------
// What this block does
// - Codes 0xa0-0xbc use map six fields
// - Codes 0xc0-0xdc use map seven fields
// - Codes 0xe0-0xfc use map eight fields
// - Map fields read/write, reset to zero
// - Reserved offsets from 0x494 read zero
// - Command register write launches table command
// - Command bit 12: one reads, zero writes
// - Command bits 11-10 choose the table
// - Command bits 9-0 give entry index
// - Pending flag during dynamic/counter reads
// - Top data register shows bits 66-64
// - Mid data register holds bits 47-32
// - Upper data register holds bits 63-48
// - Low data register holds bits 15-0
// - Lower-mid data register holds bits 31-16
//------------------------------------------------------------------
package swreg_pkg;

  //------------------------------------------------------------
  // Register indices (byte address is four times the index)
  //------------------------------------------------------------
  localparam logic [11:0] IDX_MAP6 = 12'h48a;
  localparam logic [11:0] IDX_MAP7 = 12'h490;
  localparam logic [11:0] IDX_MAP8 = 12'h492;
  localparam logic [11:0] IDX_RSVD_LO = 12'h494;
  localparam logic [11:0] IDX_RSVD_HI = 12'h49e;
  localparam logic [11:0] IDX_CMD = 12'h4a0;
  localparam logic [11:0] IDX_DATA_TOP = 12'h4a2;
  localparam logic [11:0] IDX_DATA_MID = 12'h4a4;
  localparam logic [11:0] IDX_DATA_UPPER = 12'h4a6;
  localparam logic [11:0] IDX_DATA_LOW = 12'h4a8;
  localparam logic [11:0] IDX_DATA_LOWER_MID = 12'h4aa;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h5f0;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'h5f1;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h5f2;

  //------------------------------------------------------------
  // Fields and reset values
  //------------------------------------------------------------
  localparam int CMD_DIR_BIT = 12;
  localparam int CMD_TBL_LSB = 10;
  localparam int CMD_IDX_MSB = 9;
  localparam int PENDING_BIT = 7;
  localparam int IRQ_READ_DONE = 0;
  localparam int IRQ_WRITE_DONE = 1;
  localparam logic [15:0] MAP_RST = 16'h0000;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //------------------------------------------------------------
  // Timing
  //------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TABLE_ACCESS_NS = 100;
  localparam int TABLE_ACCESS_CYCLES =
    (TABLE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //------------------------------------------------------------
  // Types
  //------------------------------------------------------------
  typedef enum logic [1:0] {
    TBL_STATIC = 2'h0,
    TBL_VLAN = 2'h1,
    TBL_DYNAMIC = 2'h2,
    TBL_MIB = 2'h3
  } table_sel_t;

  typedef struct packed {
    logic is_read;
    table_sel_t table_sel;
    logic [9:0] index;
  } table_cmd_t;

  typedef struct packed {
    logic [2:0] top;
    logic [15:0] upper;
    logic [15:0] mid;
    logic [15:0] lower_mid;
    logic [15:0] low;
  } table_entry_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_WAIT = 3'b010,
    ENG_DONE = 3'b100
  } engine_state_t;

endpackage

// >>> table_engine.sv
// Indirect table store and its timed access sequencer
`timescale 1ns/1ps
module table_engine import swreg_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command
  input wire logic start,
  input wire table_cmd_t cmd,
  input wire table_entry_t wr_entry,
  // Status and result
  output logic busy,
  output logic done,
  output logic done_read,
  output table_entry_t rd_entry
);

  localparam logic [2:0] ACCESS_CNT = 3'(TABLE_ACCESS_CYCLES);

  engine_state_t state_q;
  logic [2:0] wait_q;
  table_cmd_t cmd_q;
  table_entry_t wr_q;
  logic access;
  // All four tables share one array, indexed by table then entry
  table_entry_t mem [0:4095];

  assign busy = (state_q != ENG_IDLE);
  assign access = (state_q == ENG_WAIT) && (wait_q == 3'h0);

  //------------------------------------------------------------
  // Sequencer
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ENG_IDLE;
      wait_q <= 3'h0;
    end else begin
      case (state_q)
        ENG_IDLE: begin
          if (start) begin
            state_q <= ENG_WAIT;
            wait_q <= ACCESS_CNT - 3'h1;
          end
        end
        ENG_WAIT: begin
          if (wait_q == 3'h0) begin
            state_q <= ENG_DONE;
          end else begin
            wait_q <= wait_q - 3'h1;
          end
        end
        ENG_DONE: state_q <= ENG_IDLE;
        default: state_q <= ENG_IDLE;
      endcase
    end
  end

  // Launch snapshot; later register writes cannot disturb a running command
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= '0;
      wr_q <= '0;
    end else if (start && !busy) begin
      cmd_q <= cmd;
      wr_q <= wr_entry;
    end
  end

  //------------------------------------------------------------
  // Table access
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (access && !cmd_q.is_read) begin
      mem[{cmd_q.table_sel, cmd_q.index}] <= wr_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_entry <= '0;
      done <= 1'b0;
      done_read <= 1'b0;
    end else begin
      done <= access;
      done_read <= access && cmd_q.is_read;
      if (access && cmd_q.is_read) begin
        rd_entry <= mem[{cmd_q.table_sel, cmd_q.index}];
      end
    end
  end

endmodule

// >>> switch_regs_assertions.sv
// Port-level checker for the switch register slice
`timescale 1ns/1ps
module switch_regs_checker import swreg_pkg::*; (
  // Clock and reset
  input wire logic CLK, input wire logic RST,
  // Register bus
  input wire logic [31:0] AWADDR, input wire logic AWVALID, input wire logic AWREADY,
  input wire logic [31:0] WDATA, input wire logic [3:0] WSTRB, input wire logic WVALID,
  input wire logic WREADY, input wire logic [1:0] BRESP, input wire logic BVALID,
  input wire logic BREADY, input wire logic [31:0] ARADDR, input wire logic ARVALID,
  input wire logic ARREADY, input wire logic [31:0] RDATA, input wire logic [1:0] RRESP,
  input wire logic RVALID, input wire logic RREADY,
  // Lookup and interrupt
  input wire logic LOOKUP_VALID, input wire logic [7:0] TOS_CODE,
  input wire logic PRIORITY_VALID, input wire logic PRIORITY_HIT,
  input wire logic [1:0] PRIORITY, input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  //------------------------------------------------------------
  // Sequences
  //------------------------------------------------------------
  sequence s_ar(logic [11:0] idx);
    ARVALID && ARREADY && ARADDR == {18'h0, idx, 2'b00};
  endsequence
  sequence s_ar_rsvd;
    ARVALID && ARREADY && ARADDR[31:14] == 18'h0 &&
      ARADDR[13:2] inside {[IDX_RSVD_LO:IDX_RSVD_HI]};
  endsequence

  //------------------------------------------------------------
  // Properties
  //------------------------------------------------------------
  property p_look_answer;
    LOOKUP_VALID |=> PRIORITY_VALID && PRIORITY_HIT == ($past(TOS_CODE) >= 8'ha0);
  endproperty
  property p_look_pulse;
    !LOOKUP_VALID |=> !PRIORITY_VALID;
  endproperty
  property p_miss_zero;
    PRIORITY_VALID && !PRIORITY_HIT |-> PRIORITY == 2'h0;
  endproperty
  property p_rsvd_zero;
    s_ar_rsvd |=> RVALID && RDATA == 32'h0 && RRESP == RESP_OKAY;
  endproperty
  property p_top_fields;
    s_ar(IDX_DATA_TOP) |=> RDATA[31:8] == 24'h0 && RDATA[6:3] == 4'h0;
  endproperty
  property p_upper_zero;
    RVALID |-> RDATA[31:16] == 16'h0;
  endproperty
  property p_rhold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
  endproperty
  property p_bhold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  property p_ar_ready;
    ARVALID && ARREADY |=> RVALID;
  endproperty

  a_look_answer: assert property (p_look_answer) else $error("lookup answer wrong");
  a_look_pulse: assert property (p_look_pulse) else $error("stray lookup answer");
  a_miss_zero: assert property (p_miss_zero) else $error("miss gives priority");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");
  a_top_fields: assert property (p_top_fields) else $error("top data bits set");
  a_upper_zero: assert property (p_upper_zero) else $error("read upper half set");
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_ar_ready: assert property (p_ar_ready) else $error("read ready wrong");
endmodule

bind switch_regs switch_regs_checker switch_regs_checker_i (
  .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
  .LOOKUP_VALID(LOOKUP_VALID), .TOS_CODE(TOS_CODE), .PRIORITY_VALID(PRIORITY_VALID),
  .PRIORITY_HIT(PRIORITY_HIT), .PRIORITY(PRIORITY), .IRQ(IRQ));

// >>> switch_regs_test.sv
// Self-checking testbench for the switch register slice
`timescale 1ns/1ps
module switch_regs_test import swreg_pkg::*;;
  //------------------------------------------------------------
  // Signals
  //------------------------------------------------------------
  logic CLK = 1'b0, RST = 1'b1;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic LOOKUP_VALID = 1'b0;
  logic [7:0] TOS_CODE = 8'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PRIORITY_VALID, PRIORITY_HIT, IRQ;
  logic [1:0] BRESP, RRESP, PRIORITY, r;
  logic [31:0] RDATA, v;
  int bad_count = 0, compares = 0;

  always #12.5 CLK = ~CLK;

  switch_regs switch_regs_i (
    .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .LOOKUP_VALID(LOOKUP_VALID), .TOS_CODE(TOS_CODE), .PRIORITY_VALID(PRIORITY_VALID),
    .PRIORITY_HIT(PRIORITY_HIT), .PRIORITY(PRIORITY), .IRQ(IRQ));

  //------------------------------------------------------------
  // Shared tasks
  //------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Ready is raised only after the request is taken, so read stalls get exercised; write responses never wait
  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    @(posedge CLK);
    AWADDR <= {18'h0, idx, 2'b00};
    WDATA <= {16'h0, d};
    WSTRB <= 4'h3;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    forever begin
      @(posedge CLK);
      if (BVALID && BREADY) break;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (!AWVALID && !WVALID) BREADY <= 1'b1;
    end
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx);
    @(posedge CLK);
    ARADDR <= {18'h0, idx, 2'b00};
    ARVALID <= 1'b1;
    forever begin
      @(posedge CLK);
      if (RVALID && RREADY) break;
      if (ARREADY) ARVALID <= 1'b0;
      if (!ARVALID) RREADY <= 1'b1;
    end
    v = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic look(input logic [7:0] c, input logic hit, input logic [1:0] pri);
    @(posedge CLK);
    LOOKUP_VALID <= 1'b1;
    TOS_CODE <= c;
    @(posedge CLK);
    LOOKUP_VALID <= 1'b0;
    @(negedge CLK);
    check({28'h0, PRIORITY_VALID, PRIORITY_HIT, PRIORITY}, {28'h0, 1'b1, hit, pri});
  endtask

  //------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------
  task automatic t_reset();
    logic [11:0] ids [9] = '{IDX_MAP6, IDX_MAP7, IDX_MAP8, IDX_CMD, IDX_DATA_TOP,
      IDX_DATA_MID, IDX_DATA_UPPER, IDX_DATA_LOW, IDX_DATA_LOWER_MID};
    foreach (ids[i]) begin
      rd(ids[i]);
      check(v, 32'h0);
    end
    $display("test reset done");
  endtask

  task automatic t_maps();
    logic [15:0] m [3] = '{16'he41b, 16'h1be4, 16'h9c63};
    logic [11:0] ids [3] = '{IDX_MAP6, IDX_MAP7, IDX_MAP8};
    foreach (m[i]) wr(ids[i], m[i]);
    foreach (m[i]) begin
      rd(ids[i]);
      check(v, {16'h0, m[i]});
    end
    // Low code bits vary to show they are ignored
    for (int k = 0; k < 24; k++) begin
      look(8'ha0 + 8'(k * 4) + 8'(k % 4), 1'b1, m[k / 8][2 * (k % 8) +: 2]);
    end
    look(8'h9f, 1'b0, 2'h0);
    $display("test maps done");
  endtask

  task automatic t_rsvd();
    rd(IDX_RSVD_LO);
    check({v[29:0], r}, 32'h0);
    wr(IDX_RSVD_HI, 16'hffff);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    rd(IDX_RSVD_HI);
    check(v, 32'h0);
    wr(IDX_DATA_TOP, 16'h0007);
    rd(IDX_DATA_TOP);
    check(v, 32'h0);
    rd(IDX_DATA_TOP + 12'h1);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    // Odd slot beside the top data register: write refused
    wr(IDX_DATA_TOP + 12'h1, 16'hffff);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test reserved done");
  endtask

  task automatic t_table();
    logic [11:0] dr [4] = '{IDX_DATA_MID, IDX_DATA_UPPER, IDX_DATA_LOW, IDX_DATA_LOWER_MID};
    logic [15:0] cw;
    int n;
    for (int t = 0; t < 4; t++) begin
      foreach (dr[i]) wr(dr[i], 16'h1000 * 16'(t + 1) + 16'(i));
      cw = {4'h0, 2'(t), 10'h3fc + 10'(t)};
      wr(IDX_CMD, cw);
      rd(IDX_CMD);
      check(v, {16'h0, cw});
      foreach (dr[i]) wr(dr[i], 16'h0);
      wr(IDX_CMD, cw | 16'h1000);
      rd(IDX_DATA_TOP);
      check(v, (t >= 2) ? 32'h80 : 32'h0);
      n = 0;
      do begin
        rd(IDX_DATA_TOP);
        n++;
      end while (v[7] !== 1'b0 && n < 20);
      check(v, 32'h0);
      repeat (8) @(posedge CLK);
      foreach (dr[i]) begin
        rd(dr[i]);
        check(v, {16'h0, 16'h1000 * 16'(t + 1) + 16'(i)});
      end
    end
    $display("test table done");
  endtask

  task automatic t_irq();
    wr(IDX_IRQ_CLEAR, 16'h3);
    wr(IDX_IRQ_ENABLE, 16'h1);
    wr(IDX_CMD, 16'h13fc);
    repeat (8) @(posedge CLK);
    check({31'h0, IRQ}, 32'h1);
    rd(IDX_IRQ_STATUS);
    check(v, 32'h1);
    wr(IDX_IRQ_CLEAR, 16'h1);
    repeat (2) @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    // Masked event: status sets, output stays low
    wr(IDX_CMD, 16'h03fc);
    repeat (8) @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    rd(IDX_IRQ_STATUS);
    check(v, 32'h2);
    $display("test irq done");
  endtask

  //------------------------------------------------------------
  // Main sequence and watchdog
  //------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_maps();
    t_rsvd();
    t_table();
    t_irq();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    final_report();
  end
endmodule
